// ===== pkg/iefw_pkg.sv
// constants for the interrupt enable, flag, edge and wake logic
package iefw_pkg;
    localparam int          ADDR_W          = 5;
    localparam int          DATA_W          = 8;
    localparam int          PORTA_W         = 8;
    localparam int          PORTB_W         = 6;
    localparam int          EDGE_W          = 6;
    // register offsets
    localparam logic [4:0]  ADDR_PORTB_WAKE = 5'h09;
    localparam logic [4:0]  ADDR_ENABLE     = 5'h0E;
    localparam logic [4:0]  ADDR_FLAGS      = 5'h0F;
    localparam logic [4:0]  ADDR_PORTA_WAKE = 5'h15;
    localparam logic [4:0]  ADDR_EDGE       = 5'h18;
    // enable and flag bit positions
    localparam int          BIT_TIMER0      = 0;
    localparam int          BIT_PORT_CHANGE = 1;
    localparam int          BIT_EXT0        = 2;
    localparam int          BIT_TIMER1      = 3;
    localparam int          BIT_LOWVOLT     = 4;
    localparam int          BIT_TIMER2      = 5;
    localparam int          BIT_WATCHDOG    = 6;
    localparam int          BIT_EXT1        = 7;
    // edge register fields
    localparam int          BIT_EXT1_SELECT = 5;
    localparam int          BIT_EXT0_SELECT = 4;
    localparam int          EXT1_CODE_LSB   = 2;
    localparam int          EXT0_CODE_LSB   = 0;
    // edge codes
    localparam logic [1:0]  EDGE_NONE       = 2'h0;
    localparam logic [1:0]  EDGE_RISE       = 2'h1;
    localparam logic [1:0]  EDGE_FALL       = 2'h2;
    localparam logic [1:0]  EDGE_BOTH       = 2'h3;
    // values after reset
    localparam logic [7:0]  ENABLE_RST      = 8'h00;
    localparam logic [7:0]  FLAGS_RST       = 8'h00;
    localparam logic [7:0]  PORTA_WAKE_RST  = 8'h7F;
    localparam logic [5:0]  PORTB_WAKE_RST  = 6'h3F;
    localparam logic [5:0]  EDGE_RST        = 6'h05;
    // cycles after reset before pin changes count
    localparam logic [1:0]  SETTLE_CYCLES   = 2'h3;
endpackage : iefw_pkg

// ===== pkg/iefw_pin_if.sv
// synchronised pin levels and their previous values
`timescale 1ns/1ps
`default_nettype none
interface iefw_pin_if #(parameter int W = 8);
    logic [W-1:0] lvl;
    logic [W-1:0] prev;
    modport src (output lvl, output prev);
    modport dst (input lvl, input prev);
endinterface : iefw_pin_if
`default_nettype wire

// ===== hw/iefw_pin_sync.sv
// two-stage pin synchroniser with a history stage
`timescale 1ns/1ps
`default_nettype none
module iefw_pin_sync #(
    parameter int W = 8
) (
    input  wire logic         mclk,
    input  wire logic         reset,
    input  wire logic [W-1:0] pins,
    iefw_pin_if.src           sync
);
    logic [W-1:0] meta;
    logic [W-1:0] stable;
    logic [W-1:0] last;

    if (W < 1 || W > 8)
    begin : g_bad_w
        $error("iefw_pin_sync: W must be 1 to 8");
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            meta   <= '0;
            stable <= '0;
            last   <= '0;
        end
        else
        begin
            meta   <= pins;
            stable <= meta;
            last   <= stable;
        end
    end

    assign sync.lvl  = stable;
    assign sync.prev = last;
endmodule : iefw_pin_sync
`default_nettype wire

// ===== hw/iefw_ext_edge.sv
// edge decode for one external interrupt pin
`timescale 1ns/1ps
`default_nettype none
module iefw_ext_edge #(
    parameter int IDX = 0
) (
    input  wire logic       mclk,
    input  wire logic       reset,
    iefw_pin_if.dst         pins,
    input  wire logic       sel,
    input  wire logic [1:0] code,
    output logic            pulse
);
    logic rise;
    logic fall;
    logic hit;

    if (IDX < 0 || IDX > 7)
    begin : g_bad_idx
        $error("iefw_ext_edge: IDX must be 0 to 7");
    end

    assign rise = pins.lvl[IDX] & ~pins.prev[IDX];
    assign fall = ~pins.lvl[IDX] & pins.prev[IDX];

    always_comb
    begin
        unique case (code)
            iefw_pkg::EDGE_RISE: hit = rise;
            iefw_pkg::EDGE_FALL: hit = fall;
            iefw_pkg::EDGE_BOTH: hit = rise | fall;
            iefw_pkg::EDGE_NONE: hit = 1'b0;
        endcase
    end

    assign pulse = sel & hit;

    property p_edge_kind;
        @(posedge mclk) disable iff (reset)
        pulse |-> (code == iefw_pkg::EDGE_RISE && pins.lvl[IDX] && !pins.prev[IDX])
               || (code == iefw_pkg::EDGE_FALL && !pins.lvl[IDX] && pins.prev[IDX])
               || (code == iefw_pkg::EDGE_BOTH && pins.lvl[IDX] != pins.prev[IDX]);
    endproperty
    a_edge_kind: assert property (p_edge_kind) else $error("edge pulse without matching edge");

    property p_gpio_quiet;
        @(posedge mclk) disable iff (reset)
        !sel |-> !pulse;
    endproperty
    a_gpio_quiet: assert property (p_gpio_quiet) else $error("edge pulse while pin is gpio");
endmodule : iefw_ext_edge
`default_nettype wire

// ===== hw/iefw_irq_ctrl.sv
// interrupt enable, flag, edge select and wake-up registers
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - enable register, bits ext1..timer0, reset zero
// - flag register mirrors enable bit layout
// - flags stay set until firmware clears
// - masked flags read back as zero
// - timer underflow and overflow set flags
// - port A/B change on a wake-enabled pin sets flag
// - low-voltage event sets its flag
// - watchdog timeout sets its flag
// - select bit makes port B pin one external
// - select bit makes port B pin zero external
// - edge codes rise, fall, both; reset rising
// - port A wake enables, bits 6..0 reset one
// - port B wake enables, bits 5..0 reset one
module iefw_irq_ctrl (
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic [4:0] addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       wr_strobe,
    input  wire logic       rd_strobe,
    output logic      [7:0] rd_data,
    input  wire logic       timer0_ovf,
    input  wire logic       timer1_udf,
    input  wire logic       timer2_udf,
    input  wire logic       lowvolt_event,
    input  wire logic       watchdog_timeout,
    input  wire logic [7:0] porta_pins,
    input  wire logic [5:0] portb_pins,
    output logic            irq_req,
    output logic            wake_req,
    output logic            ext0_pin_select,
    output logic            ext1_pin_select
);
    logic [7:0] irq_enable_mask;
    logic [7:0] irq_event_flags;
    logic [7:0] porta_wake_enables;
    logic [5:0] portb_wake_enables;
    logic [5:0] ext_pin_edge_config;
    logic [7:0] next_flags;
    logic [7:0] flag_set;
    logic [7:0] flag_clr;
    logic [1:0] settle_cnt;
    logic       armed;
    logic [7:0] porta_change;
    logic [5:0] portb_change;
    logic       port_change_evt;
    logic       ext0_pulse;
    logic       ext1_pulse;
    logic       wr_enable;
    logic       wr_flags;
    logic       wr_porta_wake;
    logic       wr_portb_wake;
    logic       wr_edge;

    iefw_pin_if #(.W(iefw_pkg::PORTA_W)) porta_if ();
    iefw_pin_if #(.W(iefw_pkg::PORTB_W)) portb_if ();

    iefw_pin_sync #(.W(iefw_pkg::PORTA_W)) u_porta_sync (
        .mclk  (mclk),
        .reset (reset),
        .pins  (porta_pins),
        .sync  (porta_if)
    );

    iefw_pin_sync #(.W(iefw_pkg::PORTB_W)) u_portb_sync (
        .mclk  (mclk),
        .reset (reset),
        .pins  (portb_pins),
        .sync  (portb_if)
    );

    iefw_ext_edge #(.IDX(0)) u_ext0_edge (
        .mclk  (mclk),
        .reset (reset),
        .pins  (portb_if),
        .sel   (ext0_pin_select),
        .code  (ext_pin_edge_config[iefw_pkg::EXT0_CODE_LSB +: 2]),
        .pulse (ext0_pulse)
    );

    iefw_ext_edge #(.IDX(1)) u_ext1_edge (
        .mclk  (mclk),
        .reset (reset),
        .pins  (portb_if),
        .sel   (ext1_pin_select),
        .code  (ext_pin_edge_config[iefw_pkg::EXT1_CODE_LSB +: 2]),
        .pulse (ext1_pulse)
    );

    // write decode
    assign wr_enable     = wr_strobe && addr == iefw_pkg::ADDR_ENABLE;
    assign wr_flags      = wr_strobe && addr == iefw_pkg::ADDR_FLAGS;
    assign wr_porta_wake = wr_strobe && addr == iefw_pkg::ADDR_PORTA_WAKE;
    assign wr_portb_wake = wr_strobe && addr == iefw_pkg::ADDR_PORTB_WAKE;
    assign wr_edge       = wr_strobe && addr == iefw_pkg::ADDR_EDGE;

    // ignore pin history until the synchroniser has filled
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            settle_cnt <= '0;
        end
        else if (!armed)
        begin
            settle_cnt <= settle_cnt + 2'h1;
        end
    end

    assign armed = settle_cnt == iefw_pkg::SETTLE_CYCLES;

    // pin change on wake-enabled pins
    assign porta_change    = (porta_if.lvl ^ porta_if.prev) & porta_wake_enables;
    assign portb_change    = (portb_if.lvl ^ portb_if.prev) & portb_wake_enables;
    assign port_change_evt = armed && (|porta_change || |portb_change);

    // event vector in flag layout
    always_comb
    begin
        flag_set = '0;
        flag_set[iefw_pkg::BIT_TIMER0]      = timer0_ovf;
        flag_set[iefw_pkg::BIT_PORT_CHANGE] = port_change_evt;
        flag_set[iefw_pkg::BIT_EXT0]        = armed & ext0_pulse;
        flag_set[iefw_pkg::BIT_TIMER1]      = timer1_udf;
        flag_set[iefw_pkg::BIT_LOWVOLT]     = lowvolt_event;
        flag_set[iefw_pkg::BIT_TIMER2]      = timer2_udf;
        flag_set[iefw_pkg::BIT_WATCHDOG]    = watchdog_timeout;
        flag_set[iefw_pkg::BIT_EXT1]        = armed & ext1_pulse;
    end

    // write one to clear; a new event in the same cycle wins
    assign flag_clr   = wr_flags ? wr_data : 8'h00;
    assign next_flags = (irq_event_flags & ~flag_clr) | flag_set;

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            irq_event_flags <= iefw_pkg::FLAGS_RST;
        end
        else
        begin
            irq_event_flags <= next_flags;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            irq_enable_mask <= iefw_pkg::ENABLE_RST;
        end
        else if (wr_enable)
        begin
            irq_enable_mask <= wr_data;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            porta_wake_enables <= iefw_pkg::PORTA_WAKE_RST;
        end
        else if (wr_porta_wake)
        begin
            porta_wake_enables <= wr_data;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            portb_wake_enables <= iefw_pkg::PORTB_WAKE_RST;
        end
        else if (wr_portb_wake)
        begin
            portb_wake_enables <= wr_data[5:0];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            ext_pin_edge_config <= iefw_pkg::EDGE_RST;
        end
        else if (wr_edge)
        begin
            ext_pin_edge_config <= wr_data[5:0];
        end
    end

    assign ext0_pin_select = ext_pin_edge_config[iefw_pkg::BIT_EXT0_SELECT];
    assign ext1_pin_select = ext_pin_edge_config[iefw_pkg::BIT_EXT1_SELECT];

    // read data stands only in the cycle after the strobe
    always_ff @(posedge mclk)
    begin
        if (reset || !rd_strobe)
        begin
            rd_data <= 8'h00;
        end
        else
        begin
            unique case (addr)
                iefw_pkg::ADDR_ENABLE:     rd_data <= irq_enable_mask;
                iefw_pkg::ADDR_FLAGS:      rd_data <= irq_event_flags & irq_enable_mask;
                iefw_pkg::ADDR_PORTA_WAKE: rd_data <= porta_wake_enables;
                iefw_pkg::ADDR_PORTB_WAKE: rd_data <= {2'h0, portb_wake_enables};
                iefw_pkg::ADDR_EDGE:       rd_data <= {2'h0, ext_pin_edge_config};
                default:                   rd_data <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            irq_req <= 1'b0;
        end
        else
        begin
            irq_req <= |(irq_event_flags & irq_enable_mask);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            wake_req <= 1'b0;
        end
        else
        begin
            wake_req <= port_change_evt;
        end
    end

    property p_enable_write;
        @(posedge mclk) disable iff (reset)
        wr_enable |=> irq_enable_mask == $past(wr_data);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable write not stored");

    property p_flags_sticky;
        @(posedge mclk) disable iff (reset)
        !wr_flags |=> (irq_event_flags & $past(irq_event_flags)) == $past(irq_event_flags);
    endproperty
    a_flags_sticky: assert property (p_flags_sticky) else $error("flag dropped without a write");

    property p_masked_read;
        @(posedge mclk) disable iff (reset)
        (rd_strobe && addr == iefw_pkg::ADDR_FLAGS)
            |=> rd_data == ($past(irq_event_flags) & $past(irq_enable_mask));
    endproperty
    a_masked_read: assert property (p_masked_read) else $error("flag read not masked by enable");

    property p_timer_flags;
        @(posedge mclk) disable iff (reset)
        (timer0_ovf || timer1_udf || timer2_udf)
            |=> (irq_event_flags[iefw_pkg::BIT_TIMER0] || !$past(timer0_ovf))
             && (irq_event_flags[iefw_pkg::BIT_TIMER1] || !$past(timer1_udf))
             && (irq_event_flags[iefw_pkg::BIT_TIMER2] || !$past(timer2_udf));
    endproperty
    a_timer_flags: assert property (p_timer_flags) else $error("timer event did not set flag");

    property p_port_change;
        @(posedge mclk) disable iff (reset)
        port_change_evt |=> irq_event_flags[iefw_pkg::BIT_PORT_CHANGE] && wake_req;
    endproperty
    a_port_change: assert property (p_port_change) else $error("pin change did not set flag");

    property p_lowvolt;
        @(posedge mclk) disable iff (reset)
        lowvolt_event |=> irq_event_flags[iefw_pkg::BIT_LOWVOLT];
    endproperty
    a_lowvolt: assert property (p_lowvolt) else $error("low-voltage event did not set flag");

    property p_watchdog;
        @(posedge mclk) disable iff (reset)
        watchdog_timeout |=> irq_event_flags[iefw_pkg::BIT_WATCHDOG];
    endproperty
    a_watchdog: assert property (p_watchdog) else $error("watchdog timeout did not set flag");

    property p_wake_write;
        @(posedge mclk) disable iff (reset)
        (wr_porta_wake || wr_portb_wake)
            |=> (porta_wake_enables == $past(wr_data) || !$past(wr_porta_wake))
             && (portb_wake_enables == $past(wr_data[5:0]) || !$past(wr_portb_wake));
    endproperty
    a_wake_write: assert property (p_wake_write) else $error("wake enable write not stored");

    property p_irq_level;
        @(posedge mclk) disable iff (reset)
        ##1 irq_req == |($past(irq_event_flags) & $past(irq_enable_mask));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt request mismatch");
endmodule : iefw_irq_ctrl
`default_nettype wire

// ===== verification/irq_enable_flag_edge_wake_test.sv
// self-checking bench for the interrupt enable, flag, edge and wake logic
`timescale 1ns/1ps
`default_nettype none
module irq_enable_flag_edge_wake_test;
    logic       mclk       = 1'b0;
    logic       reset      = 1'b1;
    logic [4:0] addr       = 5'h00;
    logic [7:0] wr_data    = 8'h00;
    logic       wr_strobe  = 1'b0;
    logic       rd_strobe  = 1'b0;
    logic [4:0] ev         = 5'h00;
    logic [7:0] porta_pins = 8'h00;
    logic [5:0] portb_pins = 6'h00;
    logic [7:0] rd_data;
    logic       irq_req;
    logic       wake_req;
    logic       ext0_pin_select;
    logic       ext1_pin_select;
    int         n_mismatch = 0;
    int         checks     = 0;
    int         n_wake     = 0;
    int         exp_wake   = 0;
    int         m_en;
    int         m_fl;
    int         m_pa;
    int         m_pb;
    int         m_edge;
    int         ev_bit [5] = '{0, 3, 5, 4, 6};
    int         addrs  [6] = '{'h0E, 'h0F, 'h15, 'h09, 'h18, 'h1F};

    iefw_irq_ctrl dut (
        .mclk             (mclk),
        .reset            (reset),
        .addr             (addr),
        .wr_data          (wr_data),
        .wr_strobe        (wr_strobe),
        .rd_strobe        (rd_strobe),
        .rd_data          (rd_data),
        .timer0_ovf       (ev[0]),
        .timer1_udf       (ev[1]),
        .timer2_udf       (ev[2]),
        .lowvolt_event    (ev[3]),
        .watchdog_timeout (ev[4]),
        .porta_pins       (porta_pins),
        .portb_pins       (portb_pins),
        .irq_req          (irq_req),
        .wake_req         (wake_req),
        .ext0_pin_select  (ext0_pin_select),
        .ext1_pin_select  (ext1_pin_select)
    );

    always #10 mclk = ~mclk;

    always @(posedge mclk)
    begin
        if (wake_req === 1'b1)
            n_wake <= n_wake + 1;
    end

    task automatic finish_test;
        $display("counts: %0d checks, %0d mismatches", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    task automatic chk8(input string name, input int exp, input logic [7:0] got);
        checks++;
        if (got !== exp[7:0])
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp[7:0], got);
        end
    endtask : chk8

    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : idle

    // model write: enable, write-one-to-clear flags, port A wake, masked port B wake and edge regs
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr      <= a;
        wr_data   <= d;
        wr_strobe <= 1'b1;
        @(posedge mclk);
        wr_strobe <= 1'b0;
        case (a)
            iefw_pkg::ADDR_ENABLE:     m_en = d;
            iefw_pkg::ADDR_FLAGS:      m_fl = m_fl & ~int'(d);
            iefw_pkg::ADDR_PORTA_WAKE: m_pa = d;
            iefw_pkg::ADDR_PORTB_WAKE: m_pb = d & 8'h3F;
            iefw_pkg::ADDR_EDGE:       m_edge = d & 8'h3F;
            default:                   ;
        endcase
    endtask : wr

    // read one register and compare with the model
    task automatic rchk(input logic [4:0] a);
        int e;
        @(posedge mclk);
        addr      <= a;
        rd_strobe <= 1'b1;
        @(posedge mclk);
        rd_strobe <= 1'b0;
        #1;
        case (a)
            iefw_pkg::ADDR_ENABLE:     e = m_en;
            iefw_pkg::ADDR_FLAGS:      e = m_fl & m_en;
            iefw_pkg::ADDR_PORTA_WAKE: e = m_pa;
            iefw_pkg::ADDR_PORTB_WAKE: e = m_pb;
            iefw_pkg::ADDR_EDGE:       e = m_edge;
            default:                   e = 0;
        endcase
        chk8($sformatf("register %h", a), e, rd_data);
    endtask : rchk

    // enable write, then its read with no gap between the strobes
    task automatic wrrd(input logic [7:0] d);
        @(posedge mclk);
        addr      <= iefw_pkg::ADDR_ENABLE;
        wr_data   <= d;
        wr_strobe <= 1'b1;
        @(posedge mclk);
        wr_strobe <= 1'b0;
        rd_strobe <= 1'b1;
        m_en = d;
        @(posedge mclk);
        rd_strobe <= 1'b0;
        #1;
        chk8("enable back to back", m_en, rd_data);
        idle(1);
        chk8("read data after its cycle", 0, rd_data);
    endtask : wrrd

    task automatic pulse(input int k);
        @(posedge mclk);
        ev[k] <= 1'b1;
        @(posedge mclk);
        ev[k] <= 1'b0;
        m_fl = m_fl | (1 << ev_bit[k]);
    endtask : pulse

    task automatic pin(input int i, input logic v);
        @(posedge mclk);
        if (i < 8)
            porta_pins[i] <= v;
        else
            portb_pins[i - 8] <= v;
        idle(6);
    endtask : pin

    initial
    begin
        repeat (100000) @(posedge mclk);
        n_mismatch++;
        $display("timeout waiting for the run to end");
        finish_test();
    end

    initial
    begin
        int r;
        int w;
        int cfg;
        void'($urandom(85945));
        m_en   = 0;
        m_fl   = 0;
        m_pa   = 'h7F;
        m_pb   = 'h3F;
        m_edge = 'h05;
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        idle(4);
        // reset values, unmapped place, reserved bits
        foreach (addrs[i])
            rchk(5'(addrs[i]));
        chk8("irq_req", 0, irq_req);
        chk8("ext0 select", 0, ext0_pin_select);
        chk8("ext1 select", 0, ext1_pin_select);
        wr(5'h1F, 8'hFF);
        wr(5'h09, 8'hFF);
        rchk(5'h1F);
        rchk(5'h09);
        wrrd(8'h81);
        $display("test reset done");
        // event sources, sticky flags, set wins over clear, masking
        wr(5'h0E, 8'hFF);
        for (int k = 0; k < 5; k++)
        begin
            pulse(k);
            rchk(5'h0F);
            chk8("irq_req", 1, irq_req);
        end
        fork
            pulse(0);
            wr(5'h0F, 8'h01);
        join
        m_fl = m_fl | 1;
        rchk(5'h0F);
        wr(5'h0F, 8'hFF);
        idle(3);
        chk8("irq_req", 0, irq_req);
        rchk(5'h0F);
        wr(5'h0E, 8'h00);
        pulse(1);
        rchk(5'h0F);
        idle(2);
        chk8("irq_req", 0, irq_req);
        wr(5'h0E, 8'h08);
        rchk(5'h0F);
        idle(2);
        chk8("irq_req", 1, irq_req);
        wr(5'h0F, 8'hFF);
        $display("test events done");
        // pin changes gated by wake enables
        wr(5'h0E, 8'hFF);
        wr(5'h15, 8'h55);
        wr(5'h09, 8'h2A);
        for (int i = 0; i < 14; i++)
        begin
            for (int v = 1; v >= 0; v--)
            begin
                pin(i, v[0]);
                w = (i < 8) ? ((m_pa >> i) & 1) : ((m_pb >> (i - 8)) & 1);
                if (w != 0)
                begin
                    m_fl = m_fl | 2;
                    exp_wake++;
                end
                rchk(5'h0F);
                wr(5'h0F, 8'hFF);
            end
        end
        chk8("wake count", exp_wake, n_wake[7:0]);
        $display("test pins done");
        // external sources: select and every edge code
        wr(5'h09, 8'h00);
        for (int s = 0; s < 2; s++)
        begin
            for (int c = 0; c < 5; c++)
            begin
                cfg = (c < 4) ? ((16 << s) | (c << (2 * s))) : (3 << (2 * s));
                wr(5'h18, cfg[7:0]);
                idle(1);
                chk8("ext0 select", (cfg >> 4) & 1, ext0_pin_select);
                chk8("ext1 select", (cfg >> 5) & 1, ext1_pin_select);
                for (int v = 1; v >= 0; v--)
                begin
                    pin(8 + s, v[0]);
                    if (c < 4 && (c == 3 || c == ((v == 1) ? 1 : 2)))
                        m_fl = m_fl | ((s == 1) ? 128 : 4);
                    rchk(5'h0F);
                    wr(5'h0F, 8'hFF);
                end
            end
        end
        $display("test edges done");
        // random masks, sources and register contents
        repeat (8)
        begin
            r = $urandom;
            wr(5'h0E, r[7:0]);
            pulse(int'(r[10:8]) % 5);
            rchk(5'h0F);
            wr(5'h0F, 8'hFF);
            wr(5'h15, r[23:16]);
            rchk(5'h15);
            wr(5'h09, r[31:24]);
            rchk(5'h09);
            wr(5'h18, r[15:8]);
            rchk(5'h18);
        end
        $display("test random done");
        // reset in mid-run with pins driven high: registers return, no false change
        pulse(4);
        wr(5'h15, 8'hFF);
        w = n_wake;
        @(posedge mclk);
        reset      <= 1'b1;
        porta_pins <= 8'hFF;
        portb_pins <= 6'h3F;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        m_en   = 0;
        m_fl   = 0;
        m_pa   = 'h7F;
        m_pb   = 'h3F;
        m_edge = 'h05;
        idle(8);
        chk8("ext0 select", 0, ext0_pin_select);
        chk8("ext1 select", 0, ext1_pin_select);
        wr(5'h0E, 8'hFF);
        foreach (addrs[i])
            rchk(5'(addrs[i]));
        chk8("irq_req", 0, irq_req);
        chk8("wake count", w, n_wake[7:0]);
        $display("test mid-run reset done");
        finish_test();
    end
endmodule : irq_enable_flag_edge_wake_test
`default_nettype wire
